/* logic/apsc_pkg.sv */
// Package for the set-point and gate-drive control block
package apsc_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_REG_SETPOINT = 8'h00;
	localparam logic [7:0] ADDR_AUX_SETPOINT = 8'h04;
	localparam logic [7:0] ADDR_PERIPH_EN = 8'h08;
	localparam logic [7:0] ADDR_DEAD_TIME = 8'h0C;
	localparam logic [7:0] ADDR_MODE_CTL = 8'h10;
	localparam logic [7:0] ADDR_TIMER_PERIOD = 8'h14;
	localparam logic [7:0] ADDR_TIMER_DUTY = 8'h18;
	localparam logic [7:0] ADDR_GAIN_TRIM = 8'h1C;

	// ------------------------------------------------------------
	// Reset values and write masks
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SETPOINT = 8'h00;
	localparam logic [7:0] RST_PERIPH_EN = 8'h04;
	localparam logic [7:0] RST_DEAD_TIME = 8'h00;
	localparam logic [7:0] RST_MODE_CTL = 8'h00;
	localparam logic [7:0] RST_TIMER = 8'h00;
	localparam logic [7:0] PERIPH_EN_MASK = 8'hF7;
	localparam logic [7:0] DEAD_TIME_MASK = 8'hFF;
	localparam logic [7:0] MODE_CTL_MASK = 8'h03;

	// ------------------------------------------------------------
	// Field positions and topology code
	// ------------------------------------------------------------
	localparam int BIT_PRI_EN = 7;
	localparam int BIT_SEC_EN = 6;
	localparam int BIT_PRI_BYP = 5;
	localparam int BIT_SEC_BYP = 4;
	localparam int BIT_PULLUP = 2;
	localparam int BIT_PRI_STEER = 1;
	localparam int BIT_SEC_STEER = 0;
	localparam int BIT_SAT_OE = 0;
	localparam logic [1:0] TOPO_MAIN = 2'h1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int DT_STEP_NS = 16;
	localparam int DT_STEP_CYC_INT = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] DT_STEP_CYC = 6'(DT_STEP_CYC_INT);

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic pri_on;
		logic sec_on;
	} apsc_drive_s;

	typedef struct packed {
		logic [7:0] regulation;
		logic [7:0] aux;
		logic aux_to_pin;
	} apsc_dac_s;
endpackage : apsc_pkg

/* logic/apsc_ctrl.sv */
// Set-point registers, gate-drive enables, dead time and PWM steering
// What this block does
// - Eight-bit regulation set-point code, read/write, zero after reset, drives loop DAC.
// - Read-only factory gain trim value is presented to software.
// - Auxiliary reference reaches the port pin only when topology select is main.
// - Eight-bit auxiliary reference code, read/write, zero after reset, no pedestal.
// - Primary and secondary drive outputs each gated by their own enable.
// - Per-driver four-bit dead-time code gives 16 to 256 ns.
// - A driver's bypass bit skips its dead time, independently.
// - Sense-pin weak pull-up follows its enable bit.
// - Primary steering drives open-loop PWM to primary driver only.
// - Secondary steering drives open-loop PWM to secondary driver only.
// - Secondary steering pulses only while overvoltage protection is active.
// - Steering frequency from timer period, duty from second timer low byte.
// - Both steering bits set: primary wins, secondary ignored.
// - Dead time delays only the turn-on edge of each drive.
// - Peripheral enable bit layout: enables 7,6; bypass 5,4; pull-up 2; steer 1,0.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module apsc_ctrl #(
	parameter logic [7:0] GAIN_TRIM = 8'h80 // Factory value stand-in, arbitrary
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic loop_pwm_pri,
	input wire logic loop_pwm_sec,
	input wire logic overvoltage_active,
	output apsc_pkg::apsc_drive_s drive,
	output apsc_pkg::apsc_dac_s dac,
	output logic sense_pin_pullup,
	output logic saturation_cmp_out_enable
);
	import apsc_pkg::*;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] regulation_setpoint, next_regulation_setpoint;
	logic [7:0] external_reference_setpoint, next_external_reference_setpoint;
	logic [7:0] peripheral_enable_one, next_peripheral_enable_one;
	logic [7:0] dead_time_setting, next_dead_time_setting;
	logic [7:0] operating_mode_ctl, next_operating_mode_ctl;
	logic [7:0] timer_period_limit, next_timer_period_limit;
	logic [7:0] second_timer_low_byte, next_second_timer_low_byte;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_en, rd_en, addr_ok;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [7:0] mask);
		merge = strb[0] ? (wd[7:0] & mask) : old;
	endfunction : merge

	always_comb begin
		addr_ok = (paddr == ADDR_REG_SETPOINT) || (paddr == ADDR_AUX_SETPOINT)
			|| (paddr == ADDR_PERIPH_EN) || (paddr == ADDR_DEAD_TIME)
			|| (paddr == ADDR_MODE_CTL) || (paddr == ADDR_TIMER_PERIOD)
			|| (paddr == ADDR_TIMER_DUTY) || (paddr == ADDR_GAIN_TRIM);
		wr_en = psel && penable && pwrite && !pready;
		rd_en = psel && penable && !pwrite && !pready;
		next_regulation_setpoint = regulation_setpoint;
		next_external_reference_setpoint = external_reference_setpoint;
		next_peripheral_enable_one = peripheral_enable_one;
		next_dead_time_setting = dead_time_setting;
		next_operating_mode_ctl = operating_mode_ctl;
		next_timer_period_limit = timer_period_limit;
		next_second_timer_low_byte = second_timer_low_byte;
		next_prdata = prdata;
		next_pready = psel && penable && !pready;
		next_pslverr = psel && penable && !pready && !addr_ok;
		if (wr_en) begin
			case (paddr)
				ADDR_REG_SETPOINT: next_regulation_setpoint =
					merge(regulation_setpoint, pwdata, pstrb, 8'hFF);
				ADDR_AUX_SETPOINT: next_external_reference_setpoint =
					merge(external_reference_setpoint, pwdata, pstrb, 8'hFF);
				ADDR_PERIPH_EN: next_peripheral_enable_one =
					merge(peripheral_enable_one, pwdata, pstrb, PERIPH_EN_MASK);
				ADDR_DEAD_TIME: next_dead_time_setting =
					merge(dead_time_setting, pwdata, pstrb, DEAD_TIME_MASK);
				ADDR_MODE_CTL: next_operating_mode_ctl =
					merge(operating_mode_ctl, pwdata, pstrb, MODE_CTL_MASK);
				ADDR_TIMER_PERIOD: next_timer_period_limit =
					merge(timer_period_limit, pwdata, pstrb, 8'hFF);
				ADDR_TIMER_DUTY: next_second_timer_low_byte =
					merge(second_timer_low_byte, pwdata, pstrb, 8'hFF);
				default: begin
				end
			endcase
		end
		if (rd_en) begin
			case (paddr)
				ADDR_REG_SETPOINT: next_prdata = {24'h000000, regulation_setpoint};
				ADDR_AUX_SETPOINT: next_prdata = {24'h000000, external_reference_setpoint};
				ADDR_PERIPH_EN: next_prdata = {24'h000000, peripheral_enable_one};
				ADDR_DEAD_TIME: next_prdata = {24'h000000, dead_time_setting};
				ADDR_MODE_CTL: next_prdata = {24'h000000, operating_mode_ctl};
				ADDR_TIMER_PERIOD: next_prdata = {24'h000000, timer_period_limit};
				ADDR_TIMER_DUTY: next_prdata = {24'h000000, second_timer_low_byte};
				ADDR_GAIN_TRIM: next_prdata = {24'h000000, GAIN_TRIM};
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regulation_setpoint <= RST_SETPOINT;
			external_reference_setpoint <= RST_SETPOINT;
			peripheral_enable_one <= RST_PERIPH_EN;
			dead_time_setting <= RST_DEAD_TIME;
			operating_mode_ctl <= RST_MODE_CTL;
			timer_period_limit <= RST_TIMER;
			second_timer_low_byte <= RST_TIMER;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			regulation_setpoint <= next_regulation_setpoint;
			external_reference_setpoint <= next_external_reference_setpoint;
			peripheral_enable_one <= next_peripheral_enable_one;
			dead_time_setting <= next_dead_time_setting;
			operating_mode_ctl <= next_operating_mode_ctl;
			timer_period_limit <= next_timer_period_limit;
			second_timer_low_byte <= next_second_timer_low_byte;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	logic [2:0] s1, s2, s3, next_s1, next_s2, next_s3;
	logic [2:0] in_stable, next_in_stable;

	always_comb begin
		next_s1 = {loop_pwm_pri, loop_pwm_sec, overvoltage_active};
		next_s2 = s1;
		next_s3 = s2;
		next_in_stable = in_stable;
		for (int i = 0; i < 3; i++) begin
			if (s2[i] == s3[i]) begin
				next_in_stable[i] = s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 3'h0;
			s2 <= 3'h0;
			s3 <= 3'h0;
			in_stable <= 3'h0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
			in_stable <= next_in_stable;
		end
	end

	// ------------------------------------------------------------
	// Steering PWM generator
	// ------------------------------------------------------------
	logic [7:0] steer_cnt, next_steer_cnt;
	logic steer_pwm, next_steer_pwm;
	logic steer_pri, steer_sec;
	logic [1:0] raw_req;

	always_comb begin
		steer_pri = peripheral_enable_one[BIT_PRI_STEER];
		steer_sec = peripheral_enable_one[BIT_SEC_STEER] && !steer_pri;
		next_steer_cnt = (steer_cnt >= timer_period_limit) ? 8'h00 : steer_cnt + 8'h01;
		next_steer_pwm = (next_steer_cnt < second_timer_low_byte);
		if (steer_pri) begin
			raw_req = {steer_pwm, 1'b0};
		end else if (steer_sec) begin
			raw_req = {1'b0, steer_pwm && in_stable[0]};
		end else begin
			raw_req = {in_stable[2], in_stable[1]};
		end
		raw_req[1] = raw_req[1] && peripheral_enable_one[BIT_PRI_EN];
		raw_req[0] = raw_req[0] && peripheral_enable_one[BIT_SEC_EN];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			steer_cnt <= 8'h00;
			steer_pwm <= 1'b0;
		end else begin
			steer_cnt <= next_steer_cnt;
			steer_pwm <= next_steer_pwm;
		end
	end

	// ------------------------------------------------------------
	// Turn-on dead time per driver
	// ------------------------------------------------------------
	logic [1:0] drv_out, next_drv_out;
	logic [5:0] dt_cnt [2], next_dt_cnt [2];
	logic [3:0] dt_code [2];
	logic [1:0] bypass;

	function automatic logic [5:0] dt_cycles(input logic [3:0] code);
		dt_cycles = 6'({2'h0, code} + 6'h01) * DT_STEP_CYC;
	endfunction : dt_cycles

	always_comb begin
		dt_code[1] = dead_time_setting[7:4];
		dt_code[0] = dead_time_setting[3:0];
		bypass = {peripheral_enable_one[BIT_PRI_BYP], peripheral_enable_one[BIT_SEC_BYP]};
		for (int d = 0; d < 2; d++) begin
			next_dt_cnt[d] = 6'h00;
			next_drv_out[d] = 1'b0;
			if (raw_req[d]) begin
				if (bypass[d]) begin
					next_drv_out[d] = 1'b1;
				end else if (drv_out[d] || (dt_cnt[d] + 6'h01 >= dt_cycles(dt_code[d]))) begin
					next_drv_out[d] = 1'b1;
					next_dt_cnt[d] = dt_cnt[d];
				end else begin
					next_dt_cnt[d] = dt_cnt[d] + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_out <= 2'h0;
			dt_cnt[0] <= 6'h00;
			dt_cnt[1] <= 6'h00;
		end else begin
			drv_out <= next_drv_out;
			dt_cnt[0] <= next_dt_cnt[0];
			dt_cnt[1] <= next_dt_cnt[1];
		end
	end

	// ------------------------------------------------------------
	// Registered analog controls
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac <= '0;
			sense_pin_pullup <= RST_PERIPH_EN[BIT_PULLUP];
			saturation_cmp_out_enable <= RST_DEAD_TIME[BIT_SAT_OE];
		end else begin
			dac.regulation <= next_regulation_setpoint;
			dac.aux <= next_external_reference_setpoint;
			dac.aux_to_pin <= (next_operating_mode_ctl[1:0] == TOPO_MAIN);
			sense_pin_pullup <= next_peripheral_enable_one[BIT_PULLUP];
			saturation_cmp_out_enable <= next_dead_time_setting[BIT_SAT_OE];
		end
	end

	assign drive = '{pri_on: drv_out[1], sec_on: drv_out[0]};
endmodule : apsc_ctrl

/* verification/apsc_ctrl_sva.sv */
// Assertion checker for the set-point and gate-drive control block
`timescale 1ns/100ps
module apsc_ctrl_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire apsc_pkg::apsc_drive_s drive,
	input wire apsc_pkg::apsc_dac_s dac,
	input wire logic sense_pin_pullup,
	input wire logic saturation_cmp_out_enable
);
	import apsc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; s_setup ##1 psel && penable; endsequence
	property p_answer; s_access |=> pready; endproperty
	property p_once; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_idle; !psel |-> !pready && !pslverr; endproperty
	property p_decode;
		pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_GAIN_TRIM);
	endproperty
	property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
	property p_reset; $rose(presetn) |-> sense_pin_pullup && drive == 2'h0; endproperty
	property p_cfg;
		!$stable({dac, sense_pin_pullup, saturation_cmp_out_enable}) |->
			$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2);
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after access");
	a_once: assert property (p_once) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("error without ready");
	a_idle: assert property (p_idle) else $error("answer while idle");
	a_decode: assert property (p_decode) else $error("wrong error decode");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_reset: assert property (p_reset) else $error("wrong outputs after reset");
	a_cfg: assert property (p_cfg) else $error("output changed without write");
endmodule : apsc_ctrl_sva

bind apsc_ctrl apsc_ctrl_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .drive, .dac, .sense_pin_pullup, .saturation_cmp_out_enable);

/* verification/apsc_gate_load.sv */
// Gate-driver load model that counts drive pulses
`timescale 1ns/100ps
module apsc_gate_load (
	input wire logic pclk,
	input wire logic clear,
	input wire apsc_pkg::apsc_drive_s drive,
	output int pri_rise,
	output int sec_rise,
	output int pri_high
);
	import apsc_pkg::*;
	apsc_drive_s last = 2'h0;
	always @(posedge pclk) begin
		last <= drive;
		pri_rise <= clear ? 0 : pri_rise + int'(drive.pri_on && !last.pri_on);
		sec_rise <= clear ? 0 : sec_rise + int'(drive.sec_on && !last.sec_on);
		pri_high <= clear ? 0 : pri_high + int'(drive.pri_on);
	end
endmodule : apsc_gate_load

/* verification/apsc_ctrl_tb.sv */
// Self-checking testbench for the set-point and gate-drive control block
`timescale 1ns/100ps
module apsc_ctrl_tb;
	import apsc_pkg::*;
	localparam logic [7:0] TRIM = 8'hA5; // Arbitrary factory trim
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clear = 1'b0;
	logic loop_pwm_pri = 1'b0, loop_pwm_sec = 1'b0, overvoltage_active = 1'b0, err, pready;
	logic pslverr, sense_pin_pullup, saturation_cmp_out_enable;
	logic [7:0] paddr = 8'h00, rd;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h722F;
	apsc_drive_s drive;
	apsc_dac_s dac;
	int pri_rise, sec_rise, pri_high, mismatches = 0, total_checks = 0;
	logic [7:0] addr_t [8] = '{ADDR_REG_SETPOINT, ADDR_AUX_SETPOINT, ADDR_PERIPH_EN,
		ADDR_DEAD_TIME, ADDR_MODE_CTL, ADDR_TIMER_PERIOD, ADDR_TIMER_DUTY, ADDR_GAIN_TRIM};
	logic [7:0] rst_t [8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, TRIM};
	logic [7:0] mask_t [8] = '{8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h00};
	logic [2:0] steer_t [4] = '{3'h2, 3'h1, 3'h5, 3'h7};
	apsc_ctrl #(.GAIN_TRIM(TRIM)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .loop_pwm_pri, .loop_pwm_sec, .overvoltage_active,
		.drive, .dac, .sense_pin_pullup, .saturation_cmp_out_enable);
	apsc_gate_load LOAD (.pclk, .clear, .drive, .pri_rise, .sec_rise, .pri_high);
	initial begin
		forever #4 pclk = ~pclk;
	end
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] reg_exp(input logic [7:0] d, input int k);
		return (d & mask_t[k]) | (rst_t[k] & ~mask_t[k]);
	endfunction : reg_exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Drive a loop request and count cycles until the gate output follows
	task automatic lat(input int i, input logic lvl, output int n);
		n = 0;
		if (i == 0) loop_pwm_pri <= lvl;
		else loop_pwm_sec <= lvl;
		do begin
			@(posedge pclk);
			n++;
		end while ((i == 0 ? drive.pri_on : drive.sec_on) !== lvl && n < 100);
	endtask : lat
	initial begin
		int c, n0, n1, f0, f1, nb;
		logic [7:0] d;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(sense_pin_pullup, 1'b1);
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, addr_t[k], 8'h00, 4'hF);
			chk(rd, rst_t[k]);
			d = rnd();
			apb(1'b1, addr_t[k], d, 4'hF);
			apb(1'b0, addr_t[k], 8'h00, 4'hF);
			chk(rd, reg_exp(d, k));
			if (k < 2) chk(k ? dac.aux : dac.regulation, d);
		end
		d = rnd();
		apb(1'b0, ADDR_GAIN_TRIM, 8'h00, 4'hF);
		c = (int'(d) * int'(rd)) >> 7;
		apb(1'b1, ADDR_REG_SETPOINT, c[7:0], 4'hF);
		apb(1'b1, ADDR_REG_SETPOINT, ~c[7:0], 4'hE);
		apb(1'b0, ADDR_REG_SETPOINT, 8'h00, 4'hF);
		chk(rd, c[7:0]);
		chk(dac.regulation, c[7:0]);
		apb(1'b0, 8'h40, 8'h00, 4'hF);
		chk(err, 1'b1);
		for (int v = 1; v < 256; v++) begin
			apb(1'b1, ADDR_AUX_SETPOINT, v[7:0], 4'hF);
			chk(dac.aux, v[7:0]);
		end
		for (int t = 0; t < 4; t++) begin
			apb(1'b1, ADDR_MODE_CTL, t[7:0], 4'hF);
			chk(dac.aux_to_pin, t[1:0] == TOPO_MAIN);
		end
		for (int i = 0; i < 2; i++) begin
			c = i ? 15 : int'(rnd() & 8'h0F);
			apb(1'b1, ADDR_PERIPH_EN, 8'h80 >> i, 4'hF);
			apb(1'b1, ADDR_DEAD_TIME, 8'h00, 4'hF);
			lat(i, 1'b1, n0);
			lat(i, 1'b0, f0);
			apb(1'b1, ADDR_DEAD_TIME, i ? 8'(c) : 8'(c << 4), 4'hF);
			lat(i, 1'b1, n1);
			lat(i, 1'b0, f1);
			chk(n1 - n0, 2 * c);
			chk(f1, f0);
			apb(1'b1, ADDR_PERIPH_EN, (8'h80 >> i) | (8'h20 >> i), 4'hF);
			lat(i, 1'b1, nb);
			chk(nb < n0, 1'b1);
			lat(i, 1'b0, f1);
			apb(1'b1, ADDR_PERIPH_EN, 8'h00, 4'hF);
			lat(i, 1'b1, nb);
			chk(nb, 100);
			lat(i, 1'b0, nb);
		end
		apb(1'b1, ADDR_DEAD_TIME, 8'h00, 4'hF);
		chk(saturation_cmp_out_enable, 1'b0);
		apb(1'b1, ADDR_TIMER_PERIOD, 8'h09, 4'hF);
		apb(1'b1, ADDR_TIMER_DUTY, 8'h03, 4'hF);
		for (int s = 0; s < 4; s++) begin
			d = 8'(steer_t[s]);
			overvoltage_active <= d[2];
			apb(1'b1, ADDR_PERIPH_EN, 8'hF0 | {6'h00, d[1:0]}, 4'hF);
			repeat (20) @(posedge pclk);
			clear <= 1'b1;
			@(posedge pclk);
			clear <= 1'b0;
			repeat (101) @(posedge pclk);
			chk(pri_rise, d[1] ? 10 : 0);
			chk(pri_high, d[1] ? 30 : 0);
			chk(sec_rise, (d[0] && d[2] && !d[1]) ? 10 : 0);
		end
		chk(sense_pin_pullup, 1'b0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		summarize();
	end
endmodule : apsc_ctrl_tb
